// >>> common/dao_defines.vh
/*
 * constants for the dual converter output control block: register offsets,
 * field positions, reset values and timing counts.
 * assumes it is included by bare name from the design files.
 */
`ifndef DAO_DEFINES_VH
`define DAO_DEFINES_VH

// register byte offsets on the avalon slave
`define DAO_REG_CTRL        6'h00
`define DAO_REG_STATUS      6'h04
`define DAO_REG_IRQ_STAT    6'h08
`define DAO_REG_IRQ_MASK    6'h0c
`define DAO_REG_CNT_A       6'h10
`define DAO_REG_CNT_B       6'h14

// ctrl fields: four-level format and stabilizer select
`define DAO_CTRL_FMT_LSB    0
`define DAO_CTRL_FMT_MSB    1
`define DAO_CTRL_RESET      2'h0

// format select levels
`define DAO_FMT_GND         2'h0
`define DAO_FMT_THIRD       2'h1
`define DAO_FMT_TWO_THIRD   2'h2
`define DAO_FMT_SUPPLY      2'h3

// per-channel power state codes, {powerdown_select, output_enable_n}
`define DAO_PWR_NORMAL      2'h0
`define DAO_PWR_HIZ         2'h1
`define DAO_PWR_NAP         2'h2
`define DAO_PWR_SLEEP       2'h3

// interrupt status bits
`define DAO_IRQ_RANGE_A     0
`define DAO_IRQ_RANGE_B     1
`define DAO_IRQ_BITS        2

// conversion pipeline latency in sample clock cycles
`define DAO_PIPE_LATENCY    5
`define DAO_RESULT_BITS     12

`endif

// >>> logic/dao_pipe_delay.v
/*
 * conversion pipeline of one channel: a shift of result words that advances
 * once per sample clock rising edge while the channel converts, output taken from a register.
 * assumes the caller gives a one-cycle advance strobe in the core_clk domain.
 */
module dao_pipe_delay #(
    parameter WIDTH = 13,
    parameter DEPTH = 5
) (
    // clock and reset
    input  wire             core_clk,
    input  wire             sys_rst,
    // stream
    input  wire             adv,
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] stage_r [0:DEPTH-1];
    integer         i;

    // word taken at advance k leaves on dout at advance k+DEPTH
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                stage_r[i] <= {WIDTH{1'b0}};
            end
            dout <= {WIDTH{1'b0}};
        end else if (adv) begin
            stage_r[0] <= din;
            for (i = 1; i < DEPTH; i = i + 1) begin
                stage_r[i] <= stage_r[i-1];
            end
            dout <= stage_r[DEPTH-1];
        end
    end

endmodule // dao_pipe_delay

// >>> logic/dao_output_ctrl.v
/*
 * digital control and output side of a dual 12-bit pipelined converter:
 * per-channel sampling, power and output-enable decode, bus swap, shared
 * format and stabilizer select, overrange flags, avalon-mm register slave.
 *
 * register map, 32-bit words at byte offsets:
 *   0x00 ctrl      [1:0] format level, 0 ground .. 3 full supply
 *   0x04 status    [1:0] power code of channel a, [3:2] of channel b,
 *                  [4] two's complement, [5] stabilizer, [6] swap pin
 *   0x08 irq stat  [0] range event channel a, [1] channel b, write one clears
 *   0x0c irq mask  same layout as irq stat
 *   0x10 count a   sample edges taken by channel a
 *   0x14 count b   sample edges taken by channel b
 * unmapped offsets read zero and ignore writes.
 * bus words, flags, oe and the stabilizer enable are registered; irq and
 * waitrequest are combinational.
 *
 * assumes all pins, the sample clocks among them, are synchronous to core_clk
 * and that raw codes arrive as offset binary with an overrange bit.
 * a sample clock must stay low for at least one core cycle between edges,
 * otherwise the edge detector merges two samples into one.
 * the format level lives in a register since a four-level pin has no
 * digital equivalent; software writes the level it would have strapped.
 * reset is asynchronous and clears every register; nothing depends on the
 * sample clocks while it is held.
 */
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`include "dao_defines.vh"

module dao_output_ctrl #(
    parameter RES_BITS = `DAO_RESULT_BITS,
    parameter LATENCY  = `DAO_PIPE_LATENCY
) (
    // clock and reset
    input  wire                core_clk,
    input  wire                sys_rst,
    // sample clocks and static control pins
    input  wire                chan_a_sample_clock,
    input  wire                chan_b_sample_clock,
    input  wire                bus_swap_select,
    input  wire                chan_a_powerdown_select,
    input  wire                chan_b_powerdown_select,
    input  wire                chan_a_output_enable_n,
    input  wire                chan_b_output_enable_n,
    // raw quantiser results, offset binary, with overrange
    input  wire [RES_BITS-1:0] chan_a_raw_code,
    input  wire                chan_a_raw_over,
    input  wire [RES_BITS-1:0] chan_b_raw_code,
    input  wire                chan_b_raw_over,
    // output buses, each with an output enable
    output reg  [RES_BITS-1:0] bus_a_result,
    output reg                 bus_a_range_flag,
    output reg                 bus_a_oe,
    output reg  [RES_BITS-1:0] bus_b_result,
    output reg                 bus_b_range_flag,
    output reg                 bus_b_oe,
    // stabilizer enable shared by both channels
    output reg                 duty_stab_en,
    // avalon-mm slave
    input  wire [5:0]          avs_address,
    input  wire                avs_read,
    input  wire                avs_write,
    input  wire [31:0]         avs_writedata,
    output reg  [31:0]         avs_readdata,
    output wire                avs_waitrequest,
    // interrupt
    output wire                irq
);

    // decode of one channel's pins into a power state code
    function [1:0] pwr_state;
        input pd;
        input oe_n;
        begin
            pwr_state = {pd, oe_n};
        end
    endfunction

    // levels 2 and 3 select two's complement
    // decode of the shared format level: two's complement when set
    function fmt_twos;
        input [1:0] lvl;
        begin
            fmt_twos = (lvl == `DAO_FMT_TWO_THIRD) || (lvl == `DAO_FMT_SUPPLY);
        end
    endfunction

    // levels 1 and 2 run the stabilizer, 0 and 3 leave it off
    // decode of the shared format level: stabilizer on when set
    function fmt_stab;
        input [1:0] lvl;
        begin
            fmt_stab = (lvl == `DAO_FMT_THIRD) || (lvl == `DAO_FMT_TWO_THIRD);
        end
    endfunction

    // state kept across cycles, and rd_nxt, the combinational read word
    reg  [1:0]          fmt_r;
    reg  [1:0]          clk_prev_r;
    reg  [`DAO_IRQ_BITS-1:0] irq_stat_r;
    reg  [`DAO_IRQ_BITS-1:0] irq_mask_r;
    reg  [31:0]         cnt_a_r;
    reg  [31:0]         cnt_b_r;
    reg                 ack_r;
    reg  [1:0]          adv_d_r;
    reg  [31:0]         rd_nxt;

    // decoded and combinational signals
    wire [1:0]          pwr_a;
    wire [1:0]          pwr_b;
    wire                conv_a;
    wire                conv_b;
    wire                drive_a;
    wire                drive_b;
    wire [1:0]          samp_clk;
    wire [1:0]          samp_edge;
    wire [1:0]          adv;
    wire [RES_BITS:0]   raw [0:1];
    wire [RES_BITS:0]   piped [0:1];
    wire [RES_BITS-1:0] fmt_code_a;
    wire [RES_BITS-1:0] fmt_code_b;
    wire                twos;
    wire                wr_en;
    wire [`DAO_IRQ_BITS-1:0] range_evt;

    // power code is {powerdown_select, output_enable_n}:
    //   00 normal, converts and drives
    //   01 converts, bus released
    //   10 nap, conversion stopped, bus released
    //   11 sleep, conversion stopped, bus released
    // released and nap differ only in whether the pipe keeps moving
    // each channel decodes its own pins
    assign pwr_a   = pwr_state(chan_a_powerdown_select, chan_a_output_enable_n);
    assign pwr_b   = pwr_state(chan_b_powerdown_select, chan_b_output_enable_n);
    // nap and sleep stop conversion, high-impedance still converts
    assign conv_a  = (pwr_a == `DAO_PWR_NORMAL) || (pwr_a == `DAO_PWR_HIZ);
    assign conv_b  = (pwr_b == `DAO_PWR_NORMAL) || (pwr_b == `DAO_PWR_HIZ);
    // only the normal state drives the pins
    assign drive_a = (pwr_a == `DAO_PWR_NORMAL);
    assign drive_b = (pwr_b == `DAO_PWR_NORMAL);

    // the sample clocks are far slower than core_clk and are treated as
    // levels; a 0->1 between two core edges is one sample edge. a clock
    // with no low core cycle between its edges would lose samples.
    // rising edges of the sample clocks, seen as synchronous levels
    assign samp_clk  = {chan_b_sample_clock, chan_a_sample_clock};
    assign samp_edge = samp_clk & ~clk_prev_r;
    assign adv       = samp_edge & {conv_b, conv_a};

    // pipe input word: overrange bit above the code
    assign raw[0] = {chan_a_raw_over, chan_a_raw_code};
    assign raw[1] = {chan_b_raw_over, chan_b_raw_code};

    // previous sample clock levels, and the advance strobe one cycle late
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_prev_r <= 2'h0;
            adv_d_r    <= 2'h0;
        end else begin
            clk_prev_r <= samp_clk;
            adv_d_r    <= adv;
        end
    end

    // the pipe stands in for the converter stages: a word captured at one
    // sample edge leaves after LATENCY further edges. a napping channel
    // holds its pipe, so its old words come out once it wakes again.
    // the overrange bit rides along so flag and word leave together
    // one pipeline per channel, each advanced by its own clock
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_chan
            dao_pipe_delay #(
                .WIDTH (RES_BITS + 1),
                .DEPTH (LATENCY)
            ) u_pipe (
                .core_clk (core_clk),
                .sys_rst  (sys_rst),
                .adv      (adv[g]),
                .din      (raw[g]),
                .dout     (piped[g])
            );
        end
    endgenerate

    // formatting is applied at the pipe output rather than at capture, so a
    // level change also reformats words already in flight; cheaper than a
    // format bit per stage and invisible to a user who keeps one level
    // one format level for both channels; msb flip gives two's complement
    assign twos       = fmt_twos(fmt_r);
    assign fmt_code_a = {piped[0][RES_BITS-1] ^ twos, piped[0][RES_BITS-2:0]};
    assign fmt_code_b = {piped[1][RES_BITS-1] ^ twos, piped[1][RES_BITS-2:0]};

    // each oe follows the state of whichever channel is routed to that
    // bus, so a swap moves the enable together with the data
    // output buses registered; swap follows the pin level directly so a
    // shared bus toggles with the tied clock, one core cycle behind
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_a_result     <= {RES_BITS{1'b0}};
            bus_a_range_flag <= 1'b0;
            bus_a_oe         <= 1'b0;
            bus_b_result     <= {RES_BITS{1'b0}};
            bus_b_range_flag <= 1'b0;
            bus_b_oe         <= 1'b0;
            duty_stab_en     <= 1'b0;
        end else begin
            duty_stab_en <= fmt_stab(fmt_r);
            if (bus_swap_select) begin
                bus_a_result     <= fmt_code_a;
                bus_a_range_flag <= piped[0][RES_BITS];
                bus_a_oe         <= drive_a;
                bus_b_result     <= fmt_code_b;
                bus_b_range_flag <= piped[1][RES_BITS];
                bus_b_oe         <= drive_b;
            end else begin
                bus_a_result     <= fmt_code_b;
                bus_a_range_flag <= piped[1][RES_BITS];
                bus_a_oe         <= drive_b;
                bus_b_result     <= fmt_code_a;
                bus_b_range_flag <= piped[0][RES_BITS];
                bus_b_oe         <= drive_a;
            end
        end
    end

    // adv_d_r lines the event up with the cycle in which the pipe output
    // has already moved, so the flag reports the word that just left
    // a result leaving the pipe with its overrange bit set is an event
    assign range_evt = {adv_d_r[1] & piped[1][RES_BITS], adv_d_r[0] & piped[0][RES_BITS]};

    // ack_r rises one cycle after a request arrives and clears itself, so
    // a master that holds its request sees exactly one wait state; one
    // that drops the request early never gets an answer
    // bus handshake: one wait cycle, then the answer at the next edge
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_en           = avs_write & ack_r;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end

    // status bits are live views of pins and settings, not latched;
    // counters are read whole and a read does not freeze them
    // read mux; unmapped offsets read zero
    always @* begin
        rd_nxt = 32'h0;
        if (avs_address == `DAO_REG_CTRL) begin
            rd_nxt[1:0] = fmt_r;
        end else if (avs_address == `DAO_REG_STATUS) begin
            rd_nxt[1:0] = pwr_a;
            rd_nxt[3:2] = pwr_b;
            rd_nxt[4]   = twos;
            rd_nxt[5]   = duty_stab_en;
            rd_nxt[6]   = bus_swap_select;
        end else if (avs_address == `DAO_REG_IRQ_STAT) begin
            rd_nxt[`DAO_IRQ_BITS-1:0] = irq_stat_r;
        end else if (avs_address == `DAO_REG_IRQ_MASK) begin
            rd_nxt[`DAO_IRQ_BITS-1:0] = irq_mask_r;
        end else if (avs_address == `DAO_REG_CNT_A) begin
            rd_nxt = cnt_a_r;
        end else if (avs_address == `DAO_REG_CNT_B) begin
            rd_nxt = cnt_b_r;
        end
    end

    // read data loaded as waitrequest drops, held until the next read
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0;
        end else if (avs_read & ~ack_r) begin
            avs_readdata <= rd_nxt;
        end
    end

    // writes land in the cycle that waitrequest is low; status and counter
    // offsets are read only and silently drop writes
    // fmt_r resets to ground level: offset binary, stabilizer off
    // writable registers; a new event beats a write-one clear
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fmt_r      <= `DAO_CTRL_RESET;
            irq_mask_r <= {`DAO_IRQ_BITS{1'b0}};
            irq_stat_r <= {`DAO_IRQ_BITS{1'b0}};
        end else begin
            if (wr_en && avs_address == `DAO_REG_CTRL) begin
                fmt_r <= avs_writedata[`DAO_CTRL_FMT_MSB:`DAO_CTRL_FMT_LSB];
            end
            if (wr_en && avs_address == `DAO_REG_IRQ_MASK) begin
                irq_mask_r <= avs_writedata[`DAO_IRQ_BITS-1:0];
            end
            if (wr_en && avs_address == `DAO_REG_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~avs_writedata[`DAO_IRQ_BITS-1:0]) | range_evt;
            end else begin
                irq_stat_r <= irq_stat_r | range_evt;
            end
        end
    end

    // they wrap after 2**32 edges; software compares differences
    // a channel with its bus released still converts, so it still counts
    // sample counters show conversion activity, frozen in nap and sleep
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_a_r <= 32'h0;
            cnt_b_r <= 32'h0;
        end else begin
            if (adv[0]) begin
                cnt_a_r <= cnt_a_r + 32'h1;
            end
            if (adv[1]) begin
                cnt_b_r <= cnt_b_r + 32'h1;
            end
        end
    end

    // level interrupt: high while any unmasked status bit is set
    assign irq = |(irq_stat_r & irq_mask_r);

endmodule // dao_output_ctrl

// >>> tb/dao_chk.sv
/*
 * port checker for the dual converter output control block.
 * assumes it is bound to the design top and sees core_clk only.
 */
module dao_chk #(
    parameter RES_BITS = 12
) (
    // clock and reset
    input logic                core_clk,
    input logic                sys_rst,
    // pins
    input logic                chan_a_sample_clock,
    input logic                bus_swap_select,
    input logic                chan_a_powerdown_select,
    input logic                chan_a_output_enable_n,
    input logic                chan_b_powerdown_select,
    input logic                chan_b_output_enable_n,
    // outputs
    input logic [RES_BITS-1:0] bus_a_result,
    input logic                bus_a_oe,
    input logic                bus_b_oe,
    input logic                duty_stab_en,
    // register bus
    input logic                avs_read,
    input logic                avs_write,
    input logic                avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // one wait cycle, then the answer
    sequence wait_one;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    // channel a idle on bus a: no sample edge, no format write
    sequence idle_a;
        (bus_swap_select && !chan_a_sample_clock && !avs_write && !chan_a_powerdown_select
         && !chan_a_output_enable_n)[*4];
    endsequence
    // channel a napping on bus a, no format write
    sequence nap_a;
        (bus_swap_select && chan_a_powerdown_select && !avs_write)[*4];
    endsequence
    a_nrm_oe_a: assert property (bus_swap_select && !chan_a_powerdown_select && !chan_a_output_enable_n |=> bus_a_oe)
        else $error("bus a not driven in normal mode");
    a_hiz_oe_a: assert property (bus_swap_select && (chan_a_powerdown_select || chan_a_output_enable_n) |=> !bus_a_oe)
        else $error("bus a driven while released");
    a_swap_oe_a: assert property (!bus_swap_select && (chan_b_powerdown_select || chan_b_output_enable_n) |=> !bus_a_oe)
        else $error("swapped bus a driven while b released");
    a_swap_oe_b: assert property (!bus_swap_select && !chan_a_powerdown_select && !chan_a_output_enable_n |=> bus_b_oe)
        else $error("swapped bus b not driven");
    a_stab_by_write: assert property ($changed(duty_stab_en) |-> $past(avs_write) || $past(avs_write, 2)
                                      || $past(avs_write, 3))
        else $error("stabilizer changed without a write");
    a_hold_no_edge: assert property (idle_a |-> $stable(bus_a_result))
        else $error("bus a changed without a sample edge");
    a_nap_frozen: assert property (nap_a |-> $stable(bus_a_result))
        else $error("bus a changed in nap");
    a_wait_one: assert property ($rose(avs_read) || $rose(avs_write) |-> wait_one)
        else $error("register answer not after one wait");
endmodule // dao_chk

bind dao_output_ctrl dao_chk #(.RES_BITS(RES_BITS)) u_chk (.*);

// >>> tb/dao_bus_sink.sv
/*
 * far-side capture logic: resolves the two result buses to wire levels.
 * assumes result, flag and enable of each bus on core_clk.
 */
module dao_bus_sink (
    // clock
    input  logic        core_clk,
    // buses from the converter
    input  logic [11:0] bus_a_result,
    input  logic        bus_a_range_flag,
    input  logic        bus_a_oe,
    input  logic [11:0] bus_b_result,
    input  logic        bus_b_range_flag,
    input  logic        bus_b_oe,
    // wire level seen by the capture logic
    output logic [12:0] wire_a,
    output logic [12:0] wire_b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [12:0] last_a, last_b;
    // a released bus flips every cycle, so stale data never matches
    assign wire_a = bus_a_oe ? {bus_a_range_flag, bus_a_result} : ~last_a;
    assign wire_b = bus_b_oe ? {bus_b_range_flag, bus_b_result} : ~last_b;
    // remember the last level of each wire
    always @(posedge core_clk) begin
        last_a <= wire_a;
        last_b <= wire_b;
    end
endmodule // dao_bus_sink

// >>> tb/dual_adc_output_control_bench.sv
/*
 * self-checking bench for the output control block with a queue model.
 * assumes dao_defines.vh on the include path and the checker bound.
 */
`include "dao_defines.vh"
module dual_adc_output_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 0, sys_rst = 1, bus_swap_select = 1;
    logic        chan_a_sample_clock = 0, chan_b_sample_clock = 0;
    logic        chan_a_powerdown_select = 0, chan_b_powerdown_select = 0;
    logic        chan_a_output_enable_n = 0, chan_b_output_enable_n = 0;
    logic [11:0] chan_a_raw_code = 0, chan_b_raw_code = 0, bus_a_result, bus_b_result;
    logic        chan_a_raw_over = 0, chan_b_raw_over = 0, avs_read = 0, avs_write = 0;
    logic        bus_a_range_flag, bus_b_range_flag, bus_a_oe, bus_b_oe;
    logic        duty_stab_en, avs_waitrequest, irq;
    logic [5:0]  avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, rd;
    logic [12:0] wire_a, wire_b;
    logic [12:0] q[2][$];
    logic [1:0]  stat = 0, mask = 0;
    logic [6:0]  sts;
    int          fails = 0, tests_run = 0, fmt = 0, lvl = 0;
    int          cnt[2] = '{0, 0};

    dao_output_ctrl dut (.*);
    dao_bus_sink sink (.*);

    // 10 MHz core clock
    always #50 core_clk = ~core_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // one avalon cycle; waitrequest is read at the edge, before that edge lands
    task automatic bus(input logic wr, input logic [5:0] adr, input logic [31:0] wd);
        int n;
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= adr;
        avs_writedata <= wd;
        for (n = 0; n < 20; n++) begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n == 20) begin
            fails++;
            end_sim();
        end
        @(posedge core_clk);
    endtask

    // one sample: clock high one cycle, low two, then compare both buses
    task automatic step;
        logic [12:0] s[2], e[2];
        bit          ok[2], en[2], pd[2];
        int          ca;
        s[0] = 13'($urandom);
        s[1] = 13'($urandom);
        {chan_a_raw_over, chan_a_raw_code} <= s[0];
        {chan_b_raw_over, chan_b_raw_code} <= s[1];
        chan_a_sample_clock <= 1'b1;
        chan_b_sample_clock <= 1'b1;
        @(posedge core_clk);
        chan_a_sample_clock <= 1'b0;
        chan_b_sample_clock <= 1'b0;
        pd[0] = chan_a_powerdown_select;
        pd[1] = chan_b_powerdown_select;
        en[0] = !pd[0] && !chan_a_output_enable_n;
        en[1] = !pd[1] && !chan_b_output_enable_n;
        for (int c = 0; c < 2; c++) begin
            ok[c] = 0;
            if (!pd[c]) begin
                q[c].push_back(s[c]);
                cnt[c]++;
            end
            if (q[c].size() == 6) begin
                e[c] = q[c].pop_front();
                ok[c] = 1;
                stat[c] = stat[c] | e[c][12];
                e[c][11] = e[c][11] ^ (lvl > 1);
            end
        end
        repeat (2) @(posedge core_clk);
        ca = bus_swap_select ? 0 : 1;
        check(bus_a_oe, en[ca]);
        check(bus_b_oe, en[1-ca]);
        if (en[ca] && ok[ca]) check(wire_a, e[ca]);
        if (en[1-ca] && ok[1-ca]) check(wire_b, e[1-ca]);
        check(duty_stab_en, lvl == 1 || lvl == 2);
        check(irq, |(stat & mask));
    endtask

    initial begin
        void'($urandom(57));
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        bus(0, `DAO_REG_CTRL, 0);
        check(rd, `DAO_CTRL_RESET);
        bus(0, 6'h3c, 0);
        check(rd, 0);
        bus(1, `DAO_REG_IRQ_MASK, 3);
        mask = 2'h3;
        // every format level, both bus orders
        for (fmt = 0; fmt < 8; fmt++) begin
            lvl = fmt % 4;
            bus(1, `DAO_REG_CTRL, lvl);
            bus(0, `DAO_REG_CTRL, 0);
            check(rd, lvl);
            bus_swap_select <= fmt[2];
            repeat (8) step();
        end
        // random power and enable pins per channel
        for (int i = 0; i < 16; i++) begin
            {chan_a_powerdown_select, chan_a_output_enable_n} <= 2'($urandom);
            {chan_b_powerdown_select, chan_b_output_enable_n} <= 2'($urandom);
            bus_swap_select <= 1'($urandom);
            repeat (2) step();
        end
        // sample counts and live status of the last pin setting
        bus(0, `DAO_REG_CNT_A, 0);
        check(rd, cnt[0]);
        bus(0, `DAO_REG_CNT_B, 0);
        check(rd, cnt[1]);
        bus(0, `DAO_REG_STATUS, 0);
        sts = {bus_swap_select, (lvl == 1) || (lvl == 2), lvl > 1,
               chan_b_powerdown_select, chan_b_output_enable_n, chan_a_powerdown_select, chan_a_output_enable_n};
        check(rd, sts);
        // status, mask and clear of the range interrupt
        bus(0, `DAO_REG_IRQ_STAT, 0);
        check(rd, stat);
        bus(1, `DAO_REG_IRQ_MASK, 0);
        check(irq, 0);
        bus(1, `DAO_REG_IRQ_MASK, 3);
        check(irq, |stat);
        bus(1, `DAO_REG_IRQ_STAT, 3);
        bus(0, `DAO_REG_IRQ_STAT, 0);
        check(rd, 0);
        check(irq, 0);
        end_sim();
    end
endmodule // dual_adc_output_control_bench
